/* design/irq_pkg.sv */
package irq_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NUM_CORES = 2;        // Subsystems sharing the block
  localparam int REG_W = 16;           // Flag and mask width
  localparam int ADDR_W = 6;           // Byte address width on the bus
  localparam int CORE_SEL_BIT = 5;     // Address bit picking the core

  // ------------------------------------------------------------------
  // Register offsets within one core's window
  // ------------------------------------------------------------------
  localparam logic [4:0] OFF_FLAG = 5'h00;    // interrupt_flag
  localparam logic [4:0] OFF_MASK = 5'h04;    // interrupt_mask
  localparam logic [4:0] OFF_BSC = 5'h08;     // bank_switch_control
  localparam logic [4:0] OFF_STATUS = 5'h0C;  // Read-only core status

  // ------------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------------
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] VALID_BITS = 16'h7EFB;  // 15, 8, 2 reserved
  localparam int BIT_PEER_REQ = 0;     // Field in bank_switch_control
  localparam int BIT_INTERPROC = 14;   // Interprocessor flag bit

  // ------------------------------------------------------------------
  // Vector table
  // ------------------------------------------------------------------
  localparam logic [6:0] VEC_RESET = 7'h00;
  localparam logic [4:0] PRIO_RESET = 5'h01;
  localparam logic [6:0] VEC_BASE = 7'h40;   // Slot of flag bit 0
  localparam logic [4:0] PRIO_BASE = 5'h03;  // Priority of flag bit 0
  localparam logic [6:0] VEC_TOP_RSVD = 7'h7C;

  // ------------------------------------------------------------------
  // Bus answers and write channel states
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;

endpackage

/* design/irq_priority_pick.sv */
`timescale 1ns/10ps
`default_nettype none

// Finds the lowest set bit: lower bit means higher priority
module irq_priority_pick #(
  parameter int WIDTH = 16
) (
  // Request bits
  input wire logic [WIDTH-1:0] pending,
  // Result
  output logic found,
  output logic [3:0] index
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  // The index port holds at most sixteen positions
  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("irq_priority_pick: WIDTH must be 1 to 16");
  end

  // ------------------------------------------------------------------
  // Scan
  // ------------------------------------------------------------------
  // Scan downward so the lowest set bit is the last to win
  always_comb begin
    found = 1'b0;
    index = 4'h0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        found = 1'b1;
        index = 4'(i);
      end
    end
  end

endmodule // irq_priority_pick

`default_nettype wire

/* design/dual_core_interrupt_flags.sv */
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dual_core_interrupt_flags
  import irq_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Bus write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Bus write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Bus write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Bus read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Bus read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt sources, one bit per core, one-cycle pulses
  input wire logic [NUM_CORES-1:0] ext_pin0_irq,
  input wire logic [NUM_CORES-1:0] ext_pin1_irq,
  input wire logic [NUM_CORES-1:0] timer_irq,
  input wire logic [NUM_CORES-1:0] port0_rx_irq,
  input wire logic [NUM_CORES-1:0] port0_tx_irq,
  input wire logic [NUM_CORES-1:0] port1_rx_irq,
  input wire logic [NUM_CORES-1:0] port1_tx_irq,
  input wire logic [NUM_CORES-1:0] port2_rx_irq,
  input wire logic [NUM_CORES-1:0] port2_tx_irq,
  input wire logic [NUM_CORES-1:0] dma_ch0_irq,
  input wire logic [NUM_CORES-1:0] dma_ch1_irq,
  input wire logic [NUM_CORES-1:0] dma_ch2_irq,
  input wire logic [NUM_CORES-1:0] dma_ch3_irq,
  input wire logic [NUM_CORES-1:0] dma_ch4_irq,
  input wire logic [NUM_CORES-1:0] dma_ch5_irq,
  input wire logic [NUM_CORES-1:0] host_port_irq,
  // Core side controls, one-cycle pulses
  input wire logic [NUM_CORES-1:0] soft_reset,
  input wire logic [NUM_CORES-1:0] sleep_exec,
  input wire logic [NUM_CORES-1:0] irq_ack,
  // Core side results
  output logic [NUM_CORES-1:0] irq_req,
  output logic [NUM_CORES-1:0][6:0] irq_vector,
  output logic [NUM_CORES-1:0][4:0] irq_priority,
  output logic deep_sleep_state
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [NUM_CORES-1:0][15:0] flag;      // Pending bits per core
  logic [NUM_CORES-1:0][15:0] mask;      // Enable bits per core
  logic [NUM_CORES-1:0][3:0] served;     // Bit shown on irq_vector
  logic [NUM_CORES-1:0] peer_request_field; // Outgoing request
  logic [NUM_CORES-1:0] peer_prev;       // Request one cycle ago
  logic [NUM_CORES-1:0] reset_pend;      // Reset vector still owed
  logic [NUM_CORES-1:0] sleep_req;       // Core ran deep sleep
  logic [NUM_CORES-1:0] peer_rise;       // Request just raised
  logic [NUM_CORES-1:0] found;           // Any enabled pending bit
  logic [NUM_CORES-1:0][3:0] index;      // Winning bit
  logic [NUM_CORES-1:0][15:0] pend;      // Flag gated by mask

  // Bus holding registers
  wr_state_t wr_state;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  logic wr_fire;          // Both halves here, write happens now
  logic wr_core;          // Target core
  logic [4:0] wr_off;     // Offset within the core window
  logic wr_mapped;        // Offset names a register
  logic [15:0] wr_lanes;  // Byte enables widened to bits

  assign wr_fire = aw_held && w_held && (wr_state == WR_COLLECT);
  assign wr_core = awaddr_q[CORE_SEL_BIT];
  assign wr_off = awaddr_q[4:0];
  assign wr_mapped = (wr_off == OFF_FLAG) || (wr_off == OFF_MASK) ||
                     (wr_off == OFF_BSC) || (wr_off == OFF_STATUS);
  assign wr_lanes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // ------------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------------
  // Address and data are taken in either order and held until the
  // response is accepted, so one write is in flight at a time
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_state <= WR_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      // Capture address
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      // Capture data
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      case (wr_state)
        WR_COLLECT: begin
          if (wr_fire) begin
            // Status is read-only, so a write there is refused too
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_mapped && wr_off != OFF_STATUS) ?
                           RESP_OKAY : RESP_SLVERR;
            wr_state <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state <= WR_COLLECT;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Per-core interrupt logic
  // ------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    logic [15:0] events;    // Sources arriving this cycle
    logic [15:0] sw_clear;  // Write-one-to-clear from software
    logic [15:0] ack_clear; // Bit retired by the core's ack
    logic wr_here;          // Bus write aimed at this core
    logic ack_take;         // Core accepts the shown vector

    assign wr_here = wr_fire && (wr_core == 1'(c));
    assign ack_take = irq_ack[c] && irq_req[c];

    // Shared slots OR their two sources; only one drives at a time
    always_comb begin
      events = 16'h0000;
      events[0] = ext_pin0_irq[c];
      events[1] = ext_pin1_irq[c];
      events[3] = timer_irq[c];
      events[4] = port0_rx_irq[c];
      events[5] = port0_tx_irq[c];
      events[6] = port2_rx_irq[c] | dma_ch0_irq[c];
      events[7] = port2_tx_irq[c] | dma_ch1_irq[c];
      events[9] = host_port_irq[c];
      events[10] = port1_rx_irq[c] | dma_ch2_irq[c];
      events[11] = port1_tx_irq[c] | dma_ch3_irq[c];
      events[12] = dma_ch4_irq[c];
      events[13] = dma_ch5_irq[c];
      // The other core's request edge lands in bit 14
      events[BIT_INTERPROC] = peer_rise[NUM_CORES-1-c];
    end

    // Software clears pending bits by writing ones
    assign sw_clear = (wr_here && wr_off == OFF_FLAG) ?
                      (wdata_q[15:0] & wr_lanes) : 16'h0000;
    assign ack_clear = (ack_take && !reset_pend[c]) ?
                       (16'h0001 << served[c]) : 16'h0000;

    // Flags: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
      if (!rstn || soft_reset[c]) begin
        flag[c] <= FLAG_RST;
      end else begin
        flag[c] <= ((flag[c] & ~(sw_clear | ack_clear)) | events)
                   & VALID_BITS;
      end
    end

    // Mask: one enables, zero masks
    always_ff @(posedge sys_clk) begin
      if (!rstn || soft_reset[c]) begin
        mask[c] <= MASK_RST;
      end else if (wr_here && wr_off == OFF_MASK) begin
        mask[c] <= ((mask[c] & ~wr_lanes) |
                    (wdata_q[15:0] & wr_lanes)) & VALID_BITS;
      end
    end

    // Outgoing request field; only its 0 to 1 edge signals the peer
    always_ff @(posedge sys_clk) begin
      if (!rstn || soft_reset[c]) begin
        peer_request_field[c] <= 1'b0;
        peer_prev[c] <= 1'b0;
      end else begin
        if (wr_here && wr_off == OFF_BSC && wstrb_q[0]) begin
          peer_request_field[c] <= wdata_q[BIT_PEER_REQ];
        end
        peer_prev[c] <= peer_request_field[c];
      end
    end
    // A held one does not repeat; the sender must write zero first
    assign peer_rise[c] = peer_request_field[c] && !peer_prev[c];

    // Reset vector is owed after either reset until acknowledged
    always_ff @(posedge sys_clk) begin
      if (!rstn || soft_reset[c]) begin
        reset_pend[c] <= 1'b1;
      end else if (ack_take && reset_pend[c]) begin
        reset_pend[c] <= 1'b0;
      end
    end

    // Sleep request stands until this core has work again
    always_ff @(posedge sys_clk) begin
      if (!rstn || soft_reset[c]) begin
        sleep_req[c] <= 1'b0;
      end else if (found[c]) begin
        sleep_req[c] <= 1'b0;
      end else if (sleep_exec[c]) begin
        sleep_req[c] <= 1'b1;
      end
    end

    // Only enabled, pending, non-reserved bits compete
    assign pend[c] = flag[c] & mask[c] & VALID_BITS;

    irq_priority_pick #(
      .WIDTH(REG_W)
    ) u_pick (
      .pending(pend[c]),
      .found(found[c]),
      .index(index[c])
    );

    // Presented request; slot is base plus 4 times the bit number, and
    // bit 14 tops out at 78h, below the reserved 7Ch slots
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        irq_req[c] <= 1'b0;
        irq_vector[c] <= VEC_RESET;
        irq_priority[c] <= PRIO_RESET;
        served[c] <= 4'h0;
      end else if (ack_take || soft_reset[c]) begin
        // Drop for one cycle so the next pick sees the retired bit
        irq_req[c] <= 1'b0;
      end else if (reset_pend[c]) begin
        irq_req[c] <= 1'b1;
        irq_vector[c] <= VEC_RESET;
        irq_priority[c] <= PRIO_RESET;
      end else begin
        irq_req[c] <= found[c];
        irq_vector[c] <= VEC_BASE + {1'b0, index[c], 2'b00};
        irq_priority[c] <= PRIO_BASE + {1'b0, index[c]};
        served[c] <= index[c];
      end
    end
  end

  // ------------------------------------------------------------------
  // Shared deep sleep
  // ------------------------------------------------------------------
  // Clocks stop only while every core holds its request, whichever
  // asked first; a waking core drops its request and the stop ends
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      deep_sleep_state <= 1'b0;
    end else begin
      deep_sleep_state <= &sleep_req;
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  logic rd_core;
  logic [4:0] rd_off;
  assign rd_core = s_axi_araddr[CORE_SEL_BIT];
  assign rd_off = s_axi_araddr[4:0];

  // Answer one cycle after the address is taken; reserved bits read 0
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (rd_off)
        OFF_FLAG: s_axi_rdata <= {16'h0000, flag[rd_core]};
        OFF_MASK: s_axi_rdata <= {16'h0000, mask[rd_core]};
        OFF_BSC: s_axi_rdata <= {31'h0, peer_request_field[rd_core]};
        OFF_STATUS: begin
          s_axi_rdata <= {16'h0000, 1'b0, irq_vector[rd_core], 5'h00,
                          reset_pend[rd_core], deep_sleep_state,
                          sleep_req[rd_core]};
        end
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence both_asleep;
    sleep_req[0] && sleep_req[1];
  endsequence

  sequence peer_raised;
    peer_request_field[0] && !peer_prev[0] && !soft_reset[1];
  endsequence

  timer_latch_a: assert property (
    timer_irq[0] && !soft_reset[0] |=> flag[0][3])
    else $error("timer event not latched in bit 3");

  reserved_zero_a: assert property (
    (flag[1] & ~VALID_BITS) == 16'h0000 && (mask[0] & 16'h8104) == 0)
    else $error("reserved flag or mask bit set");

  peer_cross_a: assert property (
    peer_raised |=> flag[1][BIT_INTERPROC])
    else $error("interprocessor request not latched on peer");

  sleep_gate_a: assert property (
    deep_sleep_state |-> $past(sleep_req[0]) && $past(sleep_req[1]))
    else $error("deep sleep without both requests");

  sleep_order_a: assert property (
    both_asleep |=> deep_sleep_state)
    else $error("deep sleep not entered after both requests");

  slot_map_a: assert property (
    irq_req[0] && irq_vector[0] != VEC_RESET |->
      irq_vector[0] == 7'((irq_priority[0] - 5'h03) * 4 + 7'h40) &&
      irq_vector[0] < VEC_TOP_RSVD)
    else $error("vector and priority disagree");

  reset_vec_a: assert property (
    soft_reset[0] ##1 !irq_ack[0] |=>
      irq_req[0] && irq_vector[0] == 7'h00 && irq_priority[0] == 5'h01)
    else $error("software reset not vectored to zero");

  mask_gate_a: assert property (
    irq_req[0] && !$past(irq_ack[0]) |->
      $past(reset_pend[0]) || $past(pend[0]) != 16'h0000)
    else $error("request raised with nothing enabled");

  pick_low_a: assert property (
    !reset_pend[0] && pend[0][0] && pend[0][1] && !irq_ack[0]
      && !soft_reset[0] |=> irq_vector[0] == 7'h40)
    else $error("higher priority pin not chosen");

endmodule // dual_core_interrupt_flags

`default_nettype wire

/* sim/irq_source_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Peripherals and pins: bench rows of flag bits become source pulses
module irq_source_model (
  // Requests from the bench, one row per core
  input wire logic [1:0][15:0] fire,
  input wire logic alt,
  // Source lines, idle low
  output logic [1:0] ext_pin0_irq,
  output logic [1:0] ext_pin1_irq,
  output logic [1:0] timer_irq,
  output logic [1:0] port0_rx_irq,
  output logic [1:0] port0_tx_irq,
  output logic [1:0] port1_rx_irq,
  output logic [1:0] port1_tx_irq,
  output logic [1:0] port2_rx_irq,
  output logic [1:0] port2_tx_irq,
  output logic [1:0] dma_ch0_irq,
  output logic [1:0] dma_ch1_irq,
  output logic [1:0] dma_ch2_irq,
  output logic [1:0] dma_ch3_irq,
  output logic [1:0] dma_ch4_irq,
  output logic [1:0] dma_ch5_irq,
  output logic [1:0] host_port_irq
);
  // One column of the request rows, gated for shared slots
  function automatic logic [1:0] col(input logic [1:0][15:0] f,
                                     input int b, input logic on);
    return {f[1][b], f[0][b]} & {2{on}};
  endfunction
  // Shared slots have one owner at a time, chosen by alt
  assign ext_pin0_irq = col(fire, 0, 1'b1);
  assign ext_pin1_irq = col(fire, 1, 1'b1);
  assign timer_irq = col(fire, 3, 1'b1);
  assign port0_rx_irq = col(fire, 4, 1'b1);
  assign port0_tx_irq = col(fire, 5, 1'b1);
  assign port2_rx_irq = col(fire, 6, !alt);
  assign dma_ch0_irq = col(fire, 6, alt);
  assign port2_tx_irq = col(fire, 7, !alt);
  assign dma_ch1_irq = col(fire, 7, alt);
  assign host_port_irq = col(fire, 9, 1'b1);
  assign port1_rx_irq = col(fire, 10, !alt);
  assign dma_ch2_irq = col(fire, 10, alt);
  assign port1_tx_irq = col(fire, 11, !alt);
  assign dma_ch3_irq = col(fire, 11, alt);
  assign dma_ch4_irq = col(fire, 12, 1'b1);
  assign dma_ch5_irq = col(fire, 13, 1'b1);
endmodule // irq_source_model

`default_nettype wire

/* sim/tb_dual_core_interrupt_flags.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_dual_core_interrupt_flags import irq_pkg::*;;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk = 0, rstn = 0, alt = 0, deep_sleep_state;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0, fa, ma;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, ve, pe;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_req;
  logic [1:0] soft_reset = '0, sleep_exec = '0, irq_ack = '0;
  logic [1:0] ext_pin0_irq, ext_pin1_irq, timer_irq, port0_rx_irq;
  logic [1:0] port0_tx_irq, port1_rx_irq, port1_tx_irq, port2_rx_irq;
  logic [1:0] port2_tx_irq, dma_ch0_irq, dma_ch1_irq, dma_ch2_irq;
  logic [1:0] dma_ch3_irq, dma_ch4_irq, dma_ch5_irq, host_port_irq;
  logic [1:0][6:0] irq_vector;
  logic [1:0][4:0] irq_priority;
  logic [1:0][15:0] fire = '0; // Source requests per core
  int err_count = 0, num_checks = 0, b, b2, c;

  dual_core_interrupt_flags uut (.sys_clk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_pin0_irq, .ext_pin1_irq, .timer_irq, .port0_rx_irq,
    .port0_tx_irq, .port1_rx_irq, .port1_tx_irq, .port2_rx_irq,
    .port2_tx_irq, .dma_ch0_irq, .dma_ch1_irq, .dma_ch2_irq, .dma_ch3_irq,
    .dma_ch4_irq, .dma_ch5_irq, .host_port_irq, .soft_reset, .sleep_exec,
    .irq_ack, .irq_req, .irq_vector, .irq_priority, .deep_sleep_state);
  irq_source_model peers (.fire, .alt, .ext_pin0_irq, .ext_pin1_irq,
    .timer_irq, .port0_rx_irq, .port0_tx_irq, .port1_rx_irq,
    .port1_tx_irq, .port2_rx_irq, .port2_tx_irq, .dma_ch0_irq,
    .dma_ch1_irq, .dma_ch2_irq, .dma_ch3_irq, .dma_ch4_irq,
    .dma_ch5_irq, .host_port_irq);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial forever #2.5 sys_clk = ~sys_clk;
  function automatic logic [5:0] ra(input int cc, input logic [4:0] o);
    return {cc[0], o};
  endfunction
  // Slot and priority of flag bits 0 to 13 as the vector table lists
  function automatic logic [31:0] slot(input int n);
    logic [7:0] t [14] = '{8'h40, 8'h44, 8'h00, 8'h4C, 8'h50, 8'h54,
      8'h58, 8'h5C, 8'h00, 8'h64, 8'h68, 8'h6C, 8'h70, 8'h74};
    return 32'(t[n]);
  endfunction
  function automatic logic [31:0] prio(input int n);
    logic [7:0] t [14] = '{8'h03, 8'h04, 8'h00, 8'h06, 8'h07, 8'h08,
      8'h09, 8'h0A, 8'h00, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10};
    return 32'(t[n]);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_irq(input int cc, input logic [31:0] q, v, p);
    chk("irq_req", q, irq_req[cc]);
    chk("irq_vector", v, irq_vector[cc]);
    chk("irq_priority", p, irq_priority[cc]);
  endtask
  // Address and data offered together; held until each is taken
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // Values read here are those sampled at this edge
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", RESP_OKAY, s_axi_bresp);
  endtask
  task automatic rchk(input string nm, input logic [5:0] a,
                      input logic [31:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(nm, e, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  // One-cycle pulse: 0 sleep, 1 soft reset, 2 ack, 3 sources
  task automatic hit(input int k, input int cc, input logic [15:0] m);
    @(posedge sys_clk);
    case (k)
      0: sleep_exec[cc] <= 1;
      1: soft_reset[cc] <= 1;
      2: irq_ack[cc] <= 1;
      default: fire[cc] <= m;
    endcase
    @(posedge sys_clk);
    sleep_exec <= '0;
    soft_reset <= '0;
    irq_ack <= '0;
    fire <= '0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out;
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    close_out();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(16042));
    repeat (10) @(posedge sys_clk);
    rstn <= 1;
    settle(2);
    rchk("status", ra(1, OFF_STATUS), 32'h4, RESP_OKAY);
    for (c = 0; c < 2; c++) begin
      chk_irq(c, 1, 7'h00, 5'h01);
      hit(2, c, 16'h0000);
      settle(1);
      chk("irq_req", 0, irq_req[c]);
    end
    rchk("flag", ra(1, OFF_FLAG), 32'h0, RESP_OKAY);
    rchk("unmapped", 6'h10, 32'h0, RESP_SLVERR);
    // Every source slot 0 to 13 on a random core and a random owner of shared slots
    for (b = 0; b < 14; b++) if (b != 2 && b != 8) begin
      c = $urandom_range(0, 1);
      alt <= 1'($urandom_range(0, 1));
      fa = ra(c, OFF_FLAG);
      ve = slot(b);
      pe = prio(b);
      wr(ra(c, OFF_MASK), 16'h1 << b);
      hit(3, c, 16'h1 << b);
      settle(2);
      chk_irq(c, 1, ve, pe);
      rchk("flag", fa, 32'h1 << b, RESP_OKAY);
      hit(2, c, 16'h0000);
      settle(1);
      chk("irq_req", 0, irq_req[c]);
      rchk("flag", fa, 32'h0, RESP_OKAY);
    end
    // A masked source stays pending but asks for nothing
    ma = ra(0, OFF_MASK);
    wr(ma, 16'h0000);
    hit(3, 0, 16'h0008);
    settle(2);
    chk("irq_req", 0, irq_req[0]);
    rchk("flag", ra(0, OFF_FLAG), 32'h8, RESP_OKAY);
    wr(ra(0, OFF_FLAG), 16'h0008);
    wr(ma, 16'hFFFF);
    rchk("mask", ma, 32'h7EFB, RESP_OKAY);
    // Two sources at once: lower number served first
    // First pass is the corner of both pins at once
    for (int i = 0; i < 5; i++) begin
      b = 0;
      b2 = 1;
      if (i > 0) begin
        do b = $urandom_range(0, 12); while (b == 2 || b == 8);
        do b2 = $urandom_range(b + 1, 13); while (b2 == 2 || b2 == 8);
      end
      hit(3, 0, (16'h1 << b) | (16'h1 << b2));
      settle(2);
      chk_irq(0, 1, slot(b), prio(b));
      hit(2, 0, 16'h0000);
      settle(2);
      chk_irq(0, 1, slot(b2), prio(b2));
      hit(2, 0, 16'h0000);
    end
    wr(ma, 16'h0000);
    // Interprocessor request from core 0 lands on core 1 only
    wr(ra(1, OFF_MASK), 16'h4000);
    wr(ra(0, OFF_BSC), 16'h0001);
    settle(2);
    chk_irq(1, 1, 7'h78, 5'h11);
    chk("irq_req", 0, irq_req[0]);
    hit(2, 1, 16'h0000);
    wr(ra(0, OFF_BSC), 16'h0000);
    wr(ra(0, OFF_BSC), 16'h0001);
    rchk("flag", ra(1, OFF_FLAG), 32'h4000, RESP_OKAY);
    wr(ra(1, OFF_FLAG), 16'h4000);
    wr(ra(1, OFF_MASK), 16'h0000);
    // Deep sleep needs both cores, in either order
    hit(0, 0, 16'h0000);
    settle(2);
    chk("deep_sleep", 0, deep_sleep_state);
    hit(0, 1, 16'h0000);
    settle(2);
    chk("deep_sleep", 1, deep_sleep_state);
    hit(1, 0, 16'h0000);
    settle(3);
    chk("deep_sleep", 0, deep_sleep_state);
    chk_irq(0, 1, 7'h00, 5'h01);
    hit(2, 0, 16'h0000);
    hit(0, 0, 16'h0000);
    settle(2);
    chk("deep_sleep", 1, deep_sleep_state);
    close_out();
  end
endmodule // tb_dual_core_interrupt_flags

`default_nettype wire
